// ### bench/cprs_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module cprs_host_model
(
  input  wire logic        clk,     // Clock.
  input  wire logic        waitReq, // Slave stall.
  output logic      [7:0]  addr,    // Byte address.
  output logic             rd,      // Read request.
  output logic             wr,      // Write request.
  output logic      [31:0] wdata    // Write data.
);
  // The bus is idle from time zero so nothing leaks out during reset.
  initial
  begin
    {addr, rd, wr, wdata} = '0;
  end

  // One transfer; the request stands until waitrequest samples low.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    begin
      addr  <= a;
      wdata <= {24'h000000, d};
      wr    <= w;
      rd    <= !w;
      @(posedge clk);
      while (waitReq !== 1'h0) @(posedge clk);
      wr <= 1'h0;
      rd <= 1'h0;
      @(posedge clk);
    end
  endtask : acc
endmodule : cprs_host_model

`default_nettype wire

// ### bench/cprs_register_slice_asserts.sv
`timescale 1ns/10ps
`default_nettype none

module cprs_register_slice_asserts
(
  input  wire logic [cprs_pkg::ADDR_W-1:0] avs_address,      // Bus.
  input  wire logic                        avs_read,         // Bus.
  input  wire logic                        avs_write,        // Bus.
  input  wire logic [cprs_pkg::DATA_W-1:0] avs_writedata,    // Bus.
  input  wire logic [cprs_pkg::DATA_W-1:0] avs_readdata,     // Bus.
  input  wire logic                        avs_waitrequest,  // Bus.
  input  wire logic                        clk,              // Clock.
  input  wire logic                        reset,            // Reset.
  input  wire logic [5:0]                  latchAddr,        // Latch.
  input  wire logic [15:0]                 checksumValue,    // Result.
  input  wire logic                        checksumLoad,     // Capture.
  input  wire logic                        driverOn,         // Driver.
  input  wire logic                        loadModulation,   // Modulate.
  input  wire logic [3:0]                  idleCondOn,       // On idle.
  input  wire logic [3:0]                  modCondOn,        // On mod.
  input  wire logic [5:0]                  regAddress,       // Address.
  input  wire logic [2:0]                  rateFactorCoarse, // Speed.
  input  wire logic [3:0]                  rateFactorFine,   // Speed.
  input  wire logic [3:0]                  appliedIdleCond,  // Applied.
  input  wire logic [3:0]                  appliedModCond    // Applied.
);
  import cprs_pkg::*;
  logic [7:0]  pageSh;
  logic [7:0]  offSh;
  logic [7:0]  spdSh;
  logic [1:0]  ctlSh;
  logic [15:0] sumSh;
  logic        wrAcc;
  logic        ovr;
  logic [5:0]  ovrAddr;
  logic [7:0]  hiExp;
  logic [7:0]  loExp;
  logic [3:0]  idleExp;
  logic [3:0]  modExp;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Register shadows move at the accept edge, the checksum shadow on the capture pulse, so they line up with the slice state.
  assign wrAcc = avs_write && !avs_waitrequest;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pageSh <= RST_REGISTER_PAGE_SEL;
      offSh  <= RST_DRIVER_OFF_COND;
      spdSh  <= RST_SERIAL_LINK_SPEED;
      ctlSh  <= RST_SLICE_CONTROL;
      sumSh  <= 16'hFFFF;
    end
    else
    begin
      if (wrAcc && avs_address == 8'h80)
        pageSh <= avs_writedata[7:0] & PAGE_WRITABLE_MASK;
      if (wrAcc && avs_address == 8'h8C)
        offSh <= avs_writedata[7:0];
      if (wrAcc && avs_address == 8'h7C)
        spdSh <= avs_writedata[7:0];
      if (wrAcc && avs_address == 8'hC0)
        ctlSh <= avs_writedata[1:0];
      if (checksumLoad)
        sumSh <= checksumValue;
    end
  end

  // Expected values; power-down wins over any programmed top bit.
  assign ovr     = pageSh[7];
  assign ovrAddr = {pageSh[1:0], latchAddr[3:0]};
  assign hiExp   = ctlSh[0] ? {<<{sumSh[15:8]}} : sumSh[15:8];
  assign loExp   = ctlSh[0] ? {<<{sumSh[7:0]}} : sumSh[7:0];
  assign idleExp = ((driverOn && !loadModulation) ? idleCondOn : offSh[7:4])
                   | (ctlSh[1] ? COND_FORCE_MSB : 4'h0);
  assign modExp  = ((driverOn && !loadModulation) ? modCondOn : offSh[3:0])
                   | (ctlSh[1] ? COND_FORCE_MSB : 4'h0);

  sequence reqWait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence wrAt(logic [7:0] a);
    wrAcc && avs_address == a;
  endsequence
  sequence rdAt(logic [7:0] a);
    avs_read && !avs_waitrequest && avs_address == a;
  endsequence

  AST_WAIT_ONE: assert property (reqWait |=> !avs_waitrequest)
    else $error("waitrequest not low one cycle after request");
  AST_WAIT_STAND: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_RATE: assert property (wrAt(8'h7C) |-> ##2
    rateFactorCoarse == spdSh[7:5] && rateFactorFine == spdSh[3:0])
    else $error("speed factors do not follow the speed register");
  AST_ADDR_OVR: assert property ($past(ovr) && !$past(reset)
    |-> regAddress == $past(ovrAddr))
    else $error("page number not used for upper address bits");
  AST_ADDR_LATCH: assert property (!$past(ovr) && !$past(reset)
    |-> regAddress == $past(latchAddr))
    else $error("address not taken from the latch alone");
  AST_PAGE_RSVD: assert property (rdAt(8'h80)
    |-> avs_readdata[6:2] == 5'h00)
    else $error("page reserved bits read nonzero");
  AST_SUM_HI: assert property (rdAt(8'h84)
    |-> avs_readdata == {24'h000000, $past(hiExp)})
    else $error("checksum high byte wrong");
  AST_SUM_LO: assert property (rdAt(8'h88)
    |-> avs_readdata == {24'h000000, $past(loExp)})
    else $error("checksum low byte wrong");
  AST_COND_IDLE: assert property (!$past(reset)
    |-> appliedIdleCond == $past(idleExp))
    else $error("applied idle conductance wrong");
  AST_COND_MOD: assert property (!$past(reset)
    |-> appliedModCond == $past(modExp))
    else $error("applied modulation conductance wrong");
  AST_PWRDN: assert property ($past(ctlSh[1]) && !$past(reset)
    |-> appliedIdleCond[3] && appliedModCond[3])
    else $error("power-down did not force conductance top bits");
endmodule : cprs_register_slice_asserts

bind cprs_register_slice cprs_register_slice_asserts u_chk
(
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .clk(clk), .reset(reset),
  .latchAddr(latchAddr), .checksumValue(checksumValue),
  .checksumLoad(checksumLoad), .driverOn(driverOn),
  .loadModulation(loadModulation), .idleCondOn(idleCondOn),
  .modCondOn(modCondOn), .regAddress(regAddress),
  .rateFactorCoarse(rateFactorCoarse), .rateFactorFine(rateFactorFine),
  .appliedIdleCond(appliedIdleCond), .appliedModCond(appliedModCond)
);

`default_nettype wire

// ### bench/cprs_register_slice_bench.sv
`timescale 1ns/10ps
`default_nettype none

module cprs_register_slice_bench;
  import cprs_pkg::*;
  logic        clk, reset, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address, x;
  logic [31:0] avs_writedata, avs_readdata;
  logic [5:0]  latchAddr, regAddress;
  logic [15:0] checksumValue;
  logic        checksumLoad, checksumDone, driverOn, loadModulation;
  logic [3:0]  idleCondOn, modCondOn, rateFactorFine, e;
  logic [3:0]  appliedIdleCond, appliedModCond;
  logic [2:0]  rateFactorCoarse;
  logic [7:0]  expQ[$];
  logic [7:0]  rstA[6] = '{8'h7C, 8'h80, 8'h84, 8'h88, 8'h8C, 8'hC0};
  logic [7:0]  rstV[6] = '{8'hEB, 8'h00, 8'hFF, 8'hFF, 8'h88, 8'h00};
  logic [1:0]  mode[3] = '{2'h0, 2'h2, 2'h3};
  int          n_errors = 0;
  int          total_checks = 0;

  cprs_register_slice DUT (.avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .clk(clk), .reset(reset), .latchAddr(latchAddr),
    .checksumValue(checksumValue), .checksumLoad(checksumLoad),
    .checksumDone(checksumDone), .driverOn(driverOn),
    .loadModulation(loadModulation), .idleCondOn(idleCondOn),
    .modCondOn(modCondOn), .regAddress(regAddress),
    .rateFactorCoarse(rateFactorCoarse), .rateFactorFine(rateFactorFine),
    .appliedIdleCond(appliedIdleCond), .appliedModCond(appliedModCond));
  cprs_host_model host (.clk(clk), .waitReq(avs_waitrequest),
    .addr(avs_address), .rd(avs_read), .wr(avs_write), .wdata(avs_writedata));

  task automatic chk(input logic [31:0] g, input logic [31:0] ex);
    total_checks++;
    if (g !== ex)
    begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, ex);
    end
  endtask : chk

  // A read notes its expected byte; the watcher compares at the accept edge.
  task automatic rdx(input logic [7:0] a, input logic [7:0] ex);
    expQ.push_back(ex);
    host.acc(1'h0, a, 8'h00);
  endtask : rdx

  task automatic wrx(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'h1, a, d);
  endtask : wrx

  task automatic results;
    n_errors += expQ.size();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // Read data are flagged fresh only at the accept edge, so they are taken right there.
  always @(posedge clk)
  begin
    if (avs_read === 1'h1 && avs_waitrequest === 1'h0 && expQ.size() > 0)
      chk(avs_readdata, {24'h000000, expQ.pop_front()});
  end

  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Cuts a hang short; the tests need well under a thousand cycles.
  initial
  begin
    #40000;
    n_errors++;
    results();
  end

  initial
  begin
    reset = 1'h1;
    {latchAddr, checksumValue, checksumLoad, checksumDone, driverOn,
     loadModulation, idleCondOn, modCondOn} = '0;
    void'($urandom(32'h59A2));
    repeat (5) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    // Reset values, then random speed factors.
    foreach (rstA[i]) rdx(rstA[i], rstV[i]);
    chk(32'(rateFactorCoarse), 32'h7);
    chk(32'(rateFactorFine), 32'hB);
    x = 8'($urandom);
    wrx(8'h7C, x);
    rdx(8'h7C, x);
    chk({29'h0, rateFactorCoarse, rateFactorFine}, {29'h0, x[7:5], x[3:0]});
    // Page override over every page number, then the latch alone.
    latchAddr <= {2'h1, 4'($urandom)}; // Top bits 01 expose the override.
    wrx(8'h80, 8'hFF);
    rdx(8'h80, 8'h83);
    for (int p = 0; p < 4; p++)
    begin
      wrx(8'h80, 8'h80 | 8'(p));
      repeat (2) @(posedge clk);
      chk(32'(regAddress), {26'h0, 2'(p), latchAddr[3:0]});
    end
    wrx(8'h80, 8'h03);
    repeat (2) @(posedge clk);
    chk(32'(regAddress), 32'(latchAddr));
    // Checksum: done flag, writes refused, bits mirrored on request.
    checksumValue <= (16'($urandom) | 16'h8080) & 16'hFEFE;
    checksumLoad  <= 1'h1;
    checksumDone  <= 1'h1;
    @(posedge clk);
    checksumLoad  <= 1'h0;
    @(posedge clk);
    rdx(8'hC0, 8'h04);
    wrx(8'h84, 8'h00);
    rdx(8'h84, checksumValue[15:8]);
    rdx(8'h88, checksumValue[7:0]);
    wrx(8'hC0, 8'h01);
    x = {<<{checksumValue[15:8]}};
    rdx(8'h84, x);
    x = {<<{checksumValue[7:0]}};
    rdx(8'h88, x);
    rdx(8'h40, 8'h00);
    rdx(8'h85, 8'h00);
    // Conductance over driver state, load modulation and power-down.
    x = 8'($urandom) & 8'h77;
    wrx(8'h8C, x);
    rdx(8'h8C, x);
    idleCondOn <= x[7:4] ^ 4'h5;
    modCondOn  <= x[3:0] ^ 4'h3;
    for (int s = 0; s < 6; s++)
    begin
      wrx(8'hC0, (s > 2) ? 8'h02 : 8'h00);
      {driverOn, loadModulation} <= mode[s % 3];
      repeat (2) @(posedge clk);
      e = (s % 3 == 1) ? idleCondOn : x[7:4];
      chk(32'(appliedIdleCond), 32'(e | ((s > 2) ? 4'h8 : 4'h0)));
      e = (s % 3 == 1) ? modCondOn : x[3:0];
      chk(32'(appliedModCond), 32'(e | ((s > 2) ? 4'h8 : 4'h0)));
    end
    rdx(8'hC0, 8'h0E);
    results();
  end
endmodule : cprs_register_slice_bench

`default_nettype wire

// ### hdl/cprs_cond_if.sv
`timescale 1ns/10ps
`default_nettype none

interface cprs_cond_if;
  logic [3:0] offIdle;
  logic [3:0] offMod;
  logic [3:0] onIdle;
  logic [3:0] onMod;
  logic       driverOn;
  logic       softPowerDown;
  logic       loadModulation;
  logic [3:0] appliedIdle;
  logic [3:0] appliedMod;

  modport ctrl
  (
    output offIdle, offMod, onIdle, onMod, driverOn, softPowerDown,
    output loadModulation,
    input  appliedIdle, appliedMod
  );

  modport sel
  (
    input  offIdle, offMod, onIdle, onMod, driverOn, softPowerDown,
    input  loadModulation,
    output appliedIdle, appliedMod
  );
endinterface : cprs_cond_if

`default_nettype wire

// ### hdl/cprs_cond_sel.sv
`timescale 1ns/10ps
`default_nettype none

module cprs_cond_sel
(
  input  wire logic   clk,   // System clock.
  input  wire logic   reset, // Synchronous reset, active high.
  cprs_cond_if.sel    cond   // Conductance fields in, applied values out.
);
  import cprs_pkg::*;

  logic [3:0] idleSrc;
  logic [3:0] modSrc;

  // Off values apply with the driver off and always for load modulation.
  always_comb
  begin
    if (!cond.driverOn || cond.loadModulation)
    begin
      idleSrc = cond.offIdle;
      modSrc  = cond.offMod;
    end
    else
    begin
      idleSrc = cond.onIdle;
      modSrc  = cond.onMod;
    end
  end

  // Registered so the analog controls never see a decode glitch.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cond.appliedIdle <= RST_DRIVER_OFF_COND[COND_IDLE_HI:COND_IDLE_LO];
      cond.appliedMod  <= RST_DRIVER_OFF_COND[COND_MOD_HI:COND_MOD_LO];
    end
    else if (cond.softPowerDown)
    begin
      cond.appliedIdle <= idleSrc | COND_FORCE_MSB;
      cond.appliedMod  <= modSrc | COND_FORCE_MSB;
    end
    else
    begin
      cond.appliedIdle <= idleSrc;
      cond.appliedMod  <= modSrc;
    end
  end
endmodule : cprs_cond_sel

`default_nettype wire

// ### hdl/cprs_pkg.sv
package cprs_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0] IDX_SERIAL_LINK_SPEED   = 6'h1F;
  localparam logic [5:0] IDX_REGISTER_PAGE_SEL   = 6'h20;
  localparam logic [5:0] IDX_CHECKSUM_HIGH       = 6'h21;
  localparam logic [5:0] IDX_CHECKSUM_LOW        = 6'h22;
  localparam logic [5:0] IDX_DRIVER_OFF_COND     = 6'h23;
  localparam logic [5:0] IDX_SLICE_CONTROL       = 6'h30;

  // Bus geometry.
  localparam int         ADDR_W                  = 8;
  localparam int         DATA_W                  = 32;

  // Reset values.
  localparam logic [7:0] RST_SERIAL_LINK_SPEED   = 8'hEB;
  localparam logic [7:0] RST_REGISTER_PAGE_SEL   = 8'h00;
  localparam logic [7:0] RST_CHECKSUM_BYTE       = 8'hFF;
  localparam logic [7:0] RST_DRIVER_OFF_COND     = 8'h88;
  localparam logic [1:0] RST_SLICE_CONTROL       = 2'h0;

  // Serial link speed fields.
  localparam int         RATE_COARSE_HI          = 7;
  localparam int         RATE_COARSE_LO          = 5;
  localparam int         RATE_FINE_HI            = 3;
  localparam int         RATE_FINE_LO            = 0;

  // Page select fields.
  localparam int         PAGE_OVERRIDE_BIT       = 7;
  localparam int         PAGE_NUMBER_HI          = 1;
  localparam int         PAGE_NUMBER_LO          = 0;
  localparam logic [7:0] PAGE_WRITABLE_MASK      = 8'h83;

  // Conductance fields.
  localparam int         COND_IDLE_HI            = 7;
  localparam int         COND_IDLE_LO            = 4;
  localparam int         COND_MOD_HI             = 3;
  localparam int         COND_MOD_LO             = 0;
  localparam logic [3:0] COND_FORCE_MSB          = 4'h8;

  // Slice control and status bits.
  localparam int         CTL_HIGH_BIT_FIRST      = 0;
  localparam int         CTL_SOFT_POWER_DOWN     = 1;
  localparam int         STS_CHECKSUM_DONE       = 2;
  localparam int         STS_DRIVER_ON           = 3;

endpackage : cprs_pkg

// ### hdl/cprs_register_slice.sv
// What this block does
// - Speed register holds 3-bit coarse factor high, 4-bit fine factor low.
// - Override on: page number supplies address bits A5 and A4.
// - Override off: address latch alone forms the whole register address.
// - Page number ignored for addressing unless override enable is one.
// - Page register bits 6 to 2 read zero; software writes zero.
// - Checksum high byte at 21h, low byte at 22h, read-only, reset ones.
// - High-bit-first reverses bits within each checksum byte, not byte order.
// - Driver-off register: idle conductance bits 7-4, modulation bits 3-0.
// - Driver-off fields apply with driver off or during load modulation; else driver-on fields.
// - Soft power-down forces the top bit of each conductance field.
// - Load modulation uses the driver-off idle and modulation values.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none

module cprs_register_slice
(
  input  wire logic [cprs_pkg::ADDR_W-1:0] avs_address,     // Byte address.
  input  wire logic                        avs_read,        // Read request.
  input  wire logic                        avs_write,       // Write request.
  input  wire logic [cprs_pkg::DATA_W-1:0] avs_writedata,   // Write data.
  output logic      [cprs_pkg::DATA_W-1:0] avs_readdata,    // Read data.
  output logic                             avs_waitrequest, // Stall master.
  input  wire logic                        clk,             // System clock.
  input  wire logic                        reset,           // Sync, high.
  input  wire logic [5:0]                  latchAddr,       // Address latch.
  input  wire logic [15:0]                 checksumValue,   // Engine result.
  input  wire logic                        checksumLoad,    // Capture pulse.
  input  wire logic                        checksumDone,    // Done flag.
  input  wire logic                        driverOn,        // Driver on.
  input  wire logic                        loadModulation,  // Card modulates.
  input  wire logic [3:0]                  idleCondOn,      // On idle field.
  input  wire logic [3:0]                  modCondOn,       // On mod field.
  output logic      [5:0]                  regAddress,      // Formed address.
  output logic      [2:0]                  rateFactorCoarse, // Speed factor.
  output logic      [3:0]                  rateFactorFine,  // Speed factor.
  output logic      [3:0]                  appliedIdleCond, // To N-driver.
  output logic      [3:0]                  appliedModCond   // To N-driver.
);
  import cprs_pkg::*;

  // Programmable state, one byte for each mapped register, two bits for slice control.
  logic [7:0]  speed_reg;
  logic [7:0]  page_reg;
  logic [7:0]  csumHigh_reg;
  logic [7:0]  csumLow_reg;
  logic [7:0]  condOff_reg;
  logic [1:0]  control_reg;
  // Handshake, read path and formed address, all registered except regAddr_next.
  logic        waitReq_reg;
  logic [31:0] rdata_reg;
  logic [5:0]  regAddr_reg;
  logic [5:0]  regAddr_next;
  // Decoded request, write strobe and the byte lanes in use.
  logic        accept;
  logic        writeGo;
  logic        aligned;
  logic [5:0]  wordIdx;
  logic [7:0]  wbyte;
  logic [7:0]  rbyte;
  logic        highBitFirst;

  // Conductance fields and applied values travel as one bundle.
  cprs_cond_if condBus ();

  // Mirror a byte; used for both checksum bytes.
  // Only bit order changes; the byte a register holds is never swapped.
  function automatic logic [7:0] mirror8(input logic [7:0] b);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = b[7-i];
    end
    return r;
  endfunction : mirror8

  // Write strobe for one register index, shared by every writable register.
  function automatic logic writeHit(input logic       go,
                                    input logic [5:0] idx,
                                    input logic [5:0] target);
    return go && (idx == target);
  endfunction : writeHit

  // Decode of the bus address; a misaligned byte address maps nowhere.
  assign aligned      = (avs_address[1:0] == 2'h0);
  assign wordIdx      = avs_address[ADDR_W-1:2];
  assign wbyte        = avs_writedata[7:0];
  assign highBitFirst = control_reg[CTL_HIGH_BIT_FIRST];
  // The access completes on the edge where waitrequest is seen low.
  assign accept       = (avs_read || avs_write) && !waitReq_reg;
  // A write lands only at the accept edge and only on an aligned address;
  // anything else is dropped without side effects.
  assign writeGo      = accept && avs_write && aligned;

  // One wait state per access gives time to register the read data.
  // Every access costs two cycles; in return the read path has no
  // combinational route from the address pins to the read data, and
  // the master never sees an answer in the cycle it raised the request.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      waitReq_reg <= 1'b1;
    end
    else if ((avs_read || avs_write) && waitReq_reg)
    begin
      waitReq_reg <= 1'b0;
    end
    else
    begin
      waitReq_reg <= 1'b1;
    end
  end

  // Read mux for the mapped registers; unmapped reads return zero.
  // Page reserved bits are masked here as well as on write, so they
  // read zero whatever path set them.
  always_comb
  begin
    rbyte = 8'h00;
    if (aligned)
    begin
      unique case (wordIdx)
        IDX_SERIAL_LINK_SPEED: rbyte = speed_reg;
        IDX_REGISTER_PAGE_SEL: rbyte = page_reg & PAGE_WRITABLE_MASK;
        IDX_CHECKSUM_HIGH:
          rbyte = highBitFirst ? mirror8(csumHigh_reg) : csumHigh_reg;
        IDX_CHECKSUM_LOW:
          rbyte = highBitFirst ? mirror8(csumLow_reg) : csumLow_reg;
        IDX_DRIVER_OFF_COND:   rbyte = condOff_reg;
        IDX_SLICE_CONTROL:
        begin
          rbyte                      = {6'h00, control_reg};
          rbyte[STS_CHECKSUM_DONE]   = checksumDone;
          rbyte[STS_DRIVER_ON]       = driverOn;
        end
        default:               rbyte = 8'h00;
      endcase
    end
  end

  // Read data is loaded in the wait cycle so it stands at the accept edge.
  // It then holds until the next read; the master must take it at the
  // accept edge, since nothing flags it stale later.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if (avs_read && waitReq_reg)
    begin
      rdata_reg <= {24'h00_0000, rbyte};
    end
  end

  // Speed factors; the baud-rate generator reads both fields.
  // Every byte value is stored; which pairs of factors give a usable
  // speed is the generator's concern, not the register's.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      speed_reg <= RST_SERIAL_LINK_SPEED;
    end
    else if (writeHit(writeGo, wordIdx, IDX_SERIAL_LINK_SPEED))
    begin
      speed_reg <= wbyte;
    end
  end

  // Page select; reserved bits are never stored, so they cannot leak out.
  // Software should write zero there, but a stray one is simply lost
  // rather than flagged.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      page_reg <= RST_REGISTER_PAGE_SEL;
    end
    else if (writeHit(writeGo, wordIdx, IDX_REGISTER_PAGE_SEL))
    begin
      page_reg <= wbyte & PAGE_WRITABLE_MASK;
    end
  end

  // Driver-off conductance, two binary-weighted nibbles.
  // The register only stores the fields; the selector below decides
  // when they reach the N-driver. Every value is legal, so nothing is
  // masked on the way in.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      condOff_reg <= RST_DRIVER_OFF_COND;
    end
    else if (writeHit(writeGo, wordIdx, IDX_DRIVER_OFF_COND))
    begin
      condOff_reg <= wbyte;
    end
  end

  // Slice control: bit order of the checksum view and soft power-down.
  // Both bits stand in for mode and power controls kept outside this
  // slice, so it can be exercised on its own. Status bits 2 and 3 are
  // read-only views of the done flag and the driver state.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      control_reg <= RST_SLICE_CONTROL;
    end
    else if (writeHit(writeGo, wordIdx, IDX_SLICE_CONTROL))
    begin
      control_reg <= wbyte[1:0];
    end
  end

  // Checksum bytes are read-only; bus writes to them are dropped.
  // A capture pulse always wins, since the engine owns these bytes. The
  // slice does not gate reads on the done flag: the host must look at it
  // first, otherwise it may read a result that is still being formed.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      csumHigh_reg <= RST_CHECKSUM_BYTE;
      csumLow_reg  <= RST_CHECKSUM_BYTE;
    end
    else if (checksumLoad)
    begin
      csumHigh_reg <= checksumValue[15:8];
      csumLow_reg  <= checksumValue[7:0];
    end
  end

  // Address formation; the page number only counts under override.
  // With override on, the latch's upper bits are dropped; with it off,
  // the page number field plays no part at all.
  always_comb
  begin
    if (page_reg[PAGE_OVERRIDE_BIT])
    begin
      regAddr_next = {page_reg[PAGE_NUMBER_HI:PAGE_NUMBER_LO],
                      latchAddr[3:0]};
    end
    else
    begin
      regAddr_next = latchAddr;
    end
  end

  // Formed address is registered, one cycle behind the latch.
  // The lag is the price of a glitch-free address for the register file.
  // Reset gives address zero until the first edge after release.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      regAddr_reg <= 6'h00;
    end
    else
    begin
      regAddr_reg <= regAddr_next;
    end
  end

  // Feed the conductance selector.
  // Soft power-down comes from the slice control register; driver state
  // and load modulation pass straight through.
  assign condBus.offIdle        = condOff_reg[COND_IDLE_HI:COND_IDLE_LO];
  assign condBus.offMod         = condOff_reg[COND_MOD_HI:COND_MOD_LO];
  assign condBus.onIdle         = idleCondOn;
  assign condBus.onMod          = modCondOn;
  assign condBus.driverOn       = driverOn;
  assign condBus.softPowerDown  = control_reg[CTL_SOFT_POWER_DOWN];
  assign condBus.loadModulation = loadModulation;

  // The selector registers its result, so applied values lag one cycle.
  cprs_cond_sel uCondSel
  (
    .clk   (clk),
    .reset (reset),
    .cond  (condBus)
  );

  // Outputs, all straight from flip-flops.
  // The speed factors are slices of the speed register, itself a flop.
  // Read data and waitrequest are the bus-side registers.
  assign avs_readdata     = rdata_reg;
  assign avs_waitrequest  = waitReq_reg;
  assign regAddress       = regAddr_reg;
  assign rateFactorCoarse = speed_reg[RATE_COARSE_HI:RATE_COARSE_LO];
  assign rateFactorFine   = speed_reg[RATE_FINE_HI:RATE_FINE_LO];
  assign appliedIdleCond  = condBus.appliedIdle;
  assign appliedModCond   = condBus.appliedMod;
endmodule : cprs_register_slice

`default_nettype wire
